// *** hdl/ssh_store_unit.sv ***
// store unit for single float stores and halfword stores, with ahb-lite control/status
// assumes operands arrive with the instruction, storage answers each request once
// Operation
// - float single stores convert source to single and write one word
// - displacement address is base plus sign-extended 16-bit offset, offset alone if base 0
// - indexed address is base plus index, index alone if base field 0
// - float update forms write address to base if base nonzero and no fault
// - halfword update writes address to base if base nonzero and no fault
// - halfword stores write source bits 16-31 to the addressed halfword
// - byte-swapped halfword store exchanges the two source bytes
// - float single stores leave float status and condition field 0 alone
// - halfword stores leave fixed-point exception and condition field 0 alone
// - displacement forms: opcode, source, base, displacement fields decoded
// - indexed forms: opcode 31, source, base, index, extended opcode, reserved bit
// - opcode 31 extended 695 is float single store with update indexed
// - opcode 31 extended 663 is float single store indexed
// - opcode 44 is plain halfword store with displacement
// - opcode 31 extended 918 is byte-swapped halfword store indexed
// - opcode 45 is halfword store with update, displacement form
// - opcode 53 is float single store with update, displacement form
`timescale 1ns/100ps
module ssh_store_unit (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    input wire logic issue_valid,
    input wire ssh_pkg::ssh_issue_t issue,
    output logic issue_ready,
    output logic store_req_valid,
    output ssh_pkg::ssh_store_req_t store_req,
    input wire logic store_req_ready,
    input wire logic store_resp_valid,
    input wire logic store_resp_fault,
    output logic wb_valid,
    output ssh_pkg::ssh_wb_t wb,
    output logic done_valid,
    output ssh_pkg::ssh_done_t done,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq
);
    ssh_pkg::ssh_state_t state_ff, nxt_state;
    logic [1:0] ctrl_ff;
    logic [ssh_pkg::ST_WIDTH-1:0] status_ff, mask_ff, nxt_status;
    logic [31:0] last_ea_ff, count_ff, hrdata_ff;
    logic dwr_ff;
    logic [7:0] daddr_ff;
    ssh_pkg::ssh_store_req_t req_ff;
    ssh_pkg::ssh_wb_t wb_ff;
    ssh_pkg::ssh_done_t done_ff;
    logic upd_ff, wb_valid_ff, done_valid_ff;

    // instruction fields
    wire [5:0] opcode = issue.instr[ssh_pkg::FLD_OPC_MSB -: 6];
    wire [4:0] float_source_field = issue.instr[ssh_pkg::FLD_SRC_MSB -: 5];
    wire [4:0] integer_source_field = issue.instr[ssh_pkg::FLD_SRC_MSB -: 5];
    wire [4:0] base_register_field = issue.instr[ssh_pkg::FLD_BASE_MSB -: 5];
    wire [4:0] index_register_field = issue.instr[ssh_pkg::FLD_INDEX_MSB -: 5];
    wire [15:0] disp = issue.instr[ssh_pkg::FLD_DISP_MSB -: 16];
    wire [9:0] xo = issue.instr[ssh_pkg::FLD_XO_MSB -: 10];

    // form decode; the reserved low bit of indexed forms is ignored
    // indexed field layout
    wire is_indexed = (opcode == ssh_pkg::OPC_INDEXED);
    wire dec_fs_upd_idx = is_indexed && (xo == ssh_pkg::XO_FSINGLE_UPD_IDX);
    wire dec_fs_idx = is_indexed && (xo == ssh_pkg::XO_FSINGLE_IDX);
    wire dec_h_swap = is_indexed && (xo == ssh_pkg::XO_HALF_SWAP_IDX);
    wire dec_h = (opcode == ssh_pkg::OPC_HALF);
    wire dec_h_upd = (opcode == ssh_pkg::OPC_HALF_UPD);
    wire dec_fs_upd = (opcode == ssh_pkg::OPC_FSINGLE_UPD);
    wire is_float = dec_fs_upd_idx || dec_fs_idx || dec_fs_upd;
    wire is_half = dec_h || dec_h_upd || dec_h_swap;
    wire legal = is_float || is_half;
    wire is_update = dec_fs_upd_idx || dec_fs_upd || dec_h_upd;
    wire use_index = dec_fs_upd_idx || dec_fs_idx || dec_h_swap;
    wire base_zero = (base_register_field == 5'h00);

    // effective address, base field 0 reads as zero not the register
    // sign-extended displacement
    wire [31:0] disp_ext = {{16{disp[15]}}, disp};
    wire [31:0] offset = use_index ? issue.index_val : disp_ext;
    wire [31:0] base_op = base_zero ? 32'h0000_0000 : issue.base_val;
    wire [31:0] effective_address = base_op + offset;

    // double to single; out-of-range exponents take the plain bit selection
    // single conversion
    wire [10:0] dexp = issue.src_float[62:52];
    wire in_denorm = (dexp <= ssh_pkg::EXP_DENORM_HI) && (dexp >= ssh_pkg::EXP_DENORM_LO);
    wire [10:0] dshift = ssh_pkg::EXP_SHIFT_BASE - dexp;
    wire [23:0] dmant = {1'b1, issue.src_float[51:29]} >> dshift[4:0];
    wire [31:0] single_val = in_denorm ? {issue.src_float[63], 8'h00, dmant[22:0]}
                                       : {issue.src_float[63:62], issue.src_float[58:29]};

    // halfword data; storage bits 00-07 are the lower-addressed, high byte
    // low source halfword
    wire [15:0] half_plain = issue.src_int[15:0];
    wire [15:0] half_swap = {issue.src_int[7:0], issue.src_int[15:8]};
    wire [15:0] half_val = dec_h_swap ? half_swap : half_plain;

    // lane placement on a big-endian word bus
    wire [1:0] ofs = effective_address[1:0];
    wire [4:0] lane_shift = {ofs, 3'b000};
    wire [31:0] half_lanes = {half_val, 16'h0000} >> lane_shift;
    wire [3:0] half_be = ssh_pkg::BE_HALF >> ofs;
    wire [31:0] store_data = is_float ? single_val : half_lanes;
    wire [3:0] store_be = is_float ? ssh_pkg::BE_WORD : half_be;

    // a crossing access is always refused; odd halfwords only when checking is on
    wire cross_word = is_float ? (ofs != 2'b00) : (ofs == 2'b11);
    wire odd_half = is_half && ofs[0];
    wire misaligned = cross_word || (odd_half && ctrl_ff[ssh_pkg::CTRL_ALIGN_CHK]);

    // issue handshake
    assign issue_ready = ce && ctrl_ff[ssh_pkg::CTRL_EN] && (state_ff == ssh_pkg::SSH_ST_IDLE);
    wire issue_fire = issue_valid && issue_ready;
    wire local_reject = issue_fire && (!legal || misaligned);
    wire req_fire = ce && (state_ff == ssh_pkg::SSH_ST_REQ) && store_req_ready;
    wire resp_fire = ce && (state_ff == ssh_pkg::SSH_ST_RESP) && store_resp_valid;

    // sequencing: issue, hold request, wait for the storage answer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ssh_pkg::SSH_ST_IDLE: begin
                if (issue_fire && legal && !misaligned) begin
                    nxt_state = ssh_pkg::SSH_ST_REQ;
                end
            end
            ssh_pkg::SSH_ST_REQ: begin
                if (req_fire) begin
                    nxt_state = ssh_pkg::SSH_ST_RESP;
                end
            end
            ssh_pkg::SSH_ST_RESP: begin
                if (resp_fire) begin
                    nxt_state = ssh_pkg::SSH_ST_IDLE;
                end
            end
            default: nxt_state = ssh_pkg::SSH_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff <= ssh_pkg::SSH_ST_IDLE;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    // request capture; nothing leaves for storage on a local fault
    // no write on fault
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            req_ff <= '0;
            upd_ff <= 1'b0;
            wb_ff <= '0;
        end else if (issue_fire) begin
            req_ff <= '{addr: effective_address, be: store_be, data: store_data};
            upd_ff <= is_update && !base_zero;
            wb_ff <= '{idx: base_register_field, ea: effective_address};
        end
    end

    assign store_req_valid = (state_ff == ssh_pkg::SSH_ST_REQ);
    assign store_req = req_ff;

    // completion and write-back pulses; fp status, cr0 and xer have no path out here
    // float and halfword update gate
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wb_valid_ff <= 1'b0;
            done_valid_ff <= 1'b0;
            done_ff <= '0;
        end else if (ce) begin
            wb_valid_ff <= resp_fire && upd_ff && !store_resp_fault;
            done_valid_ff <= local_reject || resp_fire;
            if (local_reject) begin
                done_ff <= '{align: legal && misaligned, dsi: 1'b0, illegal: !legal, updated: 1'b0};
            end else if (resp_fire) begin
                done_ff <= '{align: 1'b0, dsi: store_resp_fault, illegal: 1'b0,
                             updated: upd_ff && !store_resp_fault};
            end
        end
    end

    assign wb_valid = wb_valid_ff;
    assign wb = wb_ff;
    assign done_valid = done_valid_ff;
    assign done = done_ff;

    // ahb-lite slave; ce low stretches the data phase so nothing is lost
    wire addr_phase = hsel && htrans[1] && hready && ce;
    wire rd_status = addr_phase && !hwrite && (haddr[7:0] == ssh_pkg::REG_STATUS);
    wire wr_ctrl = ce && dwr_ff && (daddr_ff == ssh_pkg::REG_CTRL);
    wire wr_mask = ce && dwr_ff && (daddr_ff == ssh_pkg::REG_MASK);
    assign hreadyout = ce;
    assign hresp = 1'b0;

    // read mux, unmapped offsets read zero
    wire [31:0] rd_ctrl = {30'h0000_0000, ctrl_ff};
    wire [31:0] rd_stat = {27'h000_0000, status_ff};
    wire [31:0] rd_mask = {27'h000_0000, mask_ff};
    wire [31:0] rd_data = (haddr[7:0] == ssh_pkg::REG_CTRL) ? rd_ctrl :
                          (haddr[7:0] == ssh_pkg::REG_STATUS) ? rd_stat :
                          (haddr[7:0] == ssh_pkg::REG_MASK) ? rd_mask :
                          (haddr[7:0] == ssh_pkg::REG_LAST_EA) ? last_ea_ff :
                          (haddr[7:0] == ssh_pkg::REG_COUNT) ? count_ff : 32'h0000_0000;

    // address phase capture and read data register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dwr_ff <= 1'b0;
            daddr_ff <= 8'h00;
            hrdata_ff <= 32'h0000_0000;
        end else if (ce) begin
            dwr_ff <= addr_phase && hwrite;
            daddr_ff <= haddr[7:0];
            if (addr_phase && !hwrite) begin
                hrdata_ff <= rd_data;
            end
        end
    end

    assign hrdata = hrdata_ff;

    // control and mask writes in the data phase
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_ff <= ssh_pkg::CTRL_RESET;
            mask_ff <= ssh_pkg::MASK_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= hwdata[1:0];
            end
            if (wr_mask) begin
                mask_ff <= hwdata[ssh_pkg::ST_WIDTH-1:0];
            end
        end
    end

    // sticky events; a new event wins over the read that clears
    wire [ssh_pkg::ST_WIDTH-1:0] events = {wb_valid_ff,
                                           done_valid_ff && done_ff.illegal,
                                           done_valid_ff && done_ff.dsi,
                                           done_valid_ff && done_ff.align,
                                           done_valid_ff};
    always_comb begin
        nxt_status = rd_status ? '0 : status_ff;
        nxt_status = nxt_status | events;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_ff <= '0;
        end else if (ce) begin
            status_ff <= nxt_status;
        end
    end

    assign irq = |(status_ff & mask_ff);

    // last address and count of stores that reached storage without fault
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            last_ea_ff <= 32'h0000_0000;
            count_ff <= 32'h0000_0000;
        end else if (resp_fire && !store_resp_fault) begin
            last_ea_ff <= req_ff.addr;
            count_ff <= count_ff + 32'h0000_0001;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_disp_addr_base0: assert property (
        (issue_fire && !use_index && base_zero && legal && !misaligned)
        |=> (store_req.addr == $past(disp_ext)))
        else $error("displacement address with base 0 wrong");

    chk_index_addr_sum: assert property (
        (issue_fire && use_index && !base_zero && legal && !misaligned)
        |=> (store_req.addr == $past(issue.base_val) + $past(issue.index_val)))
        else $error("indexed address not base plus index");

    chk_float_word_store: assert property (
        (issue_fire && is_float && !misaligned)
        |=> store_req_valid && (store_req.be == ssh_pkg::BE_WORD) && (store_req.data == $past(single_val)))
        else $error("float store not a full word");

    chk_swap_half_bytes: assert property (
        (issue_fire && dec_h_swap && !misaligned && (ofs == 2'b00))
        |=> (store_req.data[31:16] == {$past(issue.src_int[7:0]), $past(issue.src_int[15:8])}))
        else $error("swapped halfword bytes wrong");

    chk_half_data_lanes: assert property (
        (issue_fire && (dec_h || dec_h_upd) && !misaligned && (ofs == 2'b10))
        |=> (store_req.data[15:0] == $past(issue.src_int[15:0])) && (store_req.be == 4'h3))
        else $error("halfword lanes wrong");

    chk_fault_no_request: assert property (
        local_reject |=> !store_req_valid [*2])
        else $error("request issued after local fault");

    chk_update_clean_only: assert property (
        wb_valid |-> done_valid && done.updated && !done.dsi && !done.align && (wb.idx != 5'h00))
        else $error("base update without clean update form");

    chk_update_follows_resp: assert property (
        (resp_fire && upd_ff && !store_resp_fault) |=> wb_valid && (wb.ea == store_req.addr))
        else $error("base update missing after clean store");

    chk_dsi_reported: assert property (
        (resp_fire && store_resp_fault) |=> done_valid && done.dsi && !wb_valid)
        else $error("storage fault not reported");

    chk_decode_legal_set: assert property (
        (issue_fire && !legal) |=> done_valid && done.illegal && !store_req_valid)
        else $error("unknown opcode accepted");

    chk_half_odd_lanes: assert property (
        (issue_fire && is_half && !misaligned && (ofs == 2'b01))
        |=> (store_req.be == 4'h6) && (store_req.data[23:8] == $past(half_val)))
        else $error("odd halfword lanes wrong");

    chk_base0_no_update: assert property (
        (issue_fire && base_zero) |=> !upd_ff)
        else $error("update armed for base field zero");

    chk_plain_no_update: assert property (
        (issue_fire && !is_update) |=> !upd_ff)
        else $error("update armed for plain form");

    cov_float_update_idx: cover property (issue_fire && dec_fs_upd_idx ##[1:20] wb_valid);
    cov_half_update_dsi: cover property (issue_fire && dec_h_upd ##[1:20] (done_valid && done.dsi));
    cov_swap_store: cover property (issue_fire && dec_h_swap ##[1:20] done_valid);
    cov_irq_raise: cover property (!irq ##1 irq);
    cov_half_odd: cover property (issue_fire && is_half && (ofs == 2'b01) ##1 store_req_valid);
endmodule // ssh_store_unit

// *** hdl/ssh_pkg.sv ***
// shared constants and carriers of the store-single/halfword unit
// assumes a 32-bit big-endian core; bit 0 of an instruction is its msb
package ssh_pkg;
    // opcodes of the handled store forms
    localparam logic [5:0] OPC_INDEXED = 6'h1f;
    localparam logic [5:0] OPC_HALF = 6'h2c;
    localparam logic [5:0] OPC_HALF_UPD = 6'h2d;
    localparam logic [5:0] OPC_FSINGLE_UPD = 6'h35;
    localparam logic [9:0] XO_FSINGLE_UPD_IDX = 10'h2b7;
    localparam logic [9:0] XO_FSINGLE_IDX = 10'h297;
    localparam logic [9:0] XO_HALF_SWAP_IDX = 10'h396;
    // field msb positions, little-endian numbering of the word
    localparam int FLD_OPC_MSB = 31;
    localparam int FLD_SRC_MSB = 25;
    localparam int FLD_BASE_MSB = 20;
    localparam int FLD_INDEX_MSB = 15;
    localparam int FLD_DISP_MSB = 15;
    localparam int FLD_XO_MSB = 10;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_LAST_EA = 8'h0c;
    localparam logic [7:0] REG_COUNT = 8'h10;
    // control bits and reset value
    localparam int CTRL_EN = 0;
    localparam int CTRL_ALIGN_CHK = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    // status / mask bits
    localparam int ST_DONE = 0;
    localparam int ST_ALIGN = 1;
    localparam int ST_DSI = 2;
    localparam int ST_ILLEGAL = 3;
    localparam int ST_UPDATE = 4;
    localparam int ST_WIDTH = 5;
    localparam logic [4:0] MASK_RESET = 5'h00;
    // double to single conversion limits and byte enable patterns
    localparam logic [10:0] EXP_DENORM_HI = 11'h380;
    localparam logic [10:0] EXP_DENORM_LO = 11'h36a;
    localparam logic [10:0] EXP_SHIFT_BASE = 11'h381;
    localparam logic [3:0] BE_HALF = 4'hc;
    localparam logic [3:0] BE_WORD = 4'hf;

    typedef enum logic [2:0] {
        SSH_ST_IDLE = 3'b001,
        SSH_ST_REQ = 3'b010,
        SSH_ST_RESP = 3'b100
    } ssh_state_t;

    typedef struct packed {
        logic [31:0] instr;
        logic [31:0] src_int;
        logic [63:0] src_float;
        logic [31:0] base_val;
        logic [31:0] index_val;
    } ssh_issue_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] be;
        logic [31:0] data;
    } ssh_store_req_t;

    typedef struct packed {
        logic [4:0] idx;
        logic [31:0] ea;
    } ssh_wb_t;

    typedef struct packed {
        logic align;
        logic dsi;
        logic illegal;
        logic updated;
    } ssh_done_t;
endpackage

// *** test/ssh_storage_model.sv ***
// storage-side model: accepts store requests and answers each one once
// assumes the unit holds a request until ready and waits for the answer
`timescale 1ns/100ps
module ssh_storage_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [3:0] stall,
    input wire logic fault_cmd,
    input wire logic store_req_valid,
    output logic store_req_ready,
    output logic store_resp_valid,
    output logic store_resp_fault,
    output logic [7:0] accepts
);
    logic [3:0] wait_ff;
    logic take;
    assign take = store_req_valid && (wait_ff >= stall);
    assign store_req_ready = take;
    // one answer per accept
    // fault line wanders when unqualified, so a careless reader is caught
    always @(posedge clk_sys) begin
        if (reset) begin
            wait_ff <= 4'h0;
            store_resp_valid <= 1'b0;
            store_resp_fault <= 1'b0;
            accepts <= 8'h00;
        end else begin
            store_resp_valid <= take;
            store_resp_fault <= take ? fault_cmd : ~store_resp_fault;
            wait_ff <= (store_req_valid && !take) ? wait_ff + 4'h1 : 4'h0;
            if (take) begin
                accepts <= accepts + 8'h01;
            end
        end
    end
endmodule // ssh_storage_model

// *** test/tb_top.sv ***
// testbench of the store unit: instruction issue and ahb-lite register tasks
// assumes one storage model on the far side and a single 10 MHz clock
`timescale 1ns/100ps
module tb_top;
    localparam logic [63:0] FP = 64'h4865_6c6c_6f20_776f;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic issue_valid = 1'b0;
    ssh_pkg::ssh_issue_t issue = '0;
    logic issue_ready, store_req_valid, store_req_ready, store_resp_valid, store_resp_fault;
    ssh_pkg::ssh_store_req_t store_req;
    logic wb_valid, done_valid, hreadyout, hresp, irq, hready;
    ssh_pkg::ssh_wb_t wb, wb_last;
    ssh_pkg::ssh_done_t done;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd, errors, num_checks, wb_seen, wb_base, cycles;
    logic [3:0] stall = 4'h0;
    logic fault_cmd = 1'b0;
    logic [7:0] accepts, acc0;
    assign hready = hreadyout;
    always #50 clk_sys = ~clk_sys;
    ssh_store_unit u_dut (.clk_sys(clk_sys), .reset(reset), .ce(1'b1), .issue_valid(issue_valid),
        .issue(issue), .issue_ready(issue_ready), .store_req_valid(store_req_valid), .store_req(store_req),
        .store_req_ready(store_req_ready), .store_resp_valid(store_resp_valid),
        .store_resp_fault(store_resp_fault), .wb_valid(wb_valid), .wb(wb), .done_valid(done_valid),
        .done(done), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
    ssh_storage_model u_mem (.clk_sys(clk_sys), .reset(reset), .stall(stall), .fault_cmd(fault_cmd),
        .store_req_valid(store_req_valid), .store_req_ready(store_req_ready),
        .store_resp_valid(store_resp_valid), .store_resp_fault(store_resp_fault), .accepts(accepts));
    // write-back pulses counted as they pass
    always @(posedge clk_sys) begin
        if (wb_valid === 1'b1) begin
            wb_seen = wb_seen + 1;
            wb_last = wb;
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // hang guard, far above the hundred or so cycles the tests need
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 32'h0000_1388) begin
            check("cycle limit", cycles, 32'h0000_0000);
            report_and_stop();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [31:0] dfm(input logic [5:0] op, input logic [4:0] s, input logic [4:0] a,
        input logic [15:0] d);
        return {op, s, a, d};
    endfunction
    function automatic logic [31:0] xfm(input logic [4:0] s, input logic [4:0] a, input logic [4:0] b,
        input logic [9:0] xo);
        return {6'h1f, s, a, b, xo, 1'b0};
    endfunction
    // one bus transfer: address phase held until hready, then data phase
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
        #1;
    endtask
    // offer one instruction, hold until taken, wait for completion
    task automatic do_op(input logic [31:0] ins, input logic [31:0] si, input logic [31:0] b,
        input logic [31:0] x);
        int n;
        n = 0;
        wb_base = wb_seen;
        issue_valid <= 1'b1;
        issue <= '{ins, si, FP, b, x};
        @(posedge clk_sys);
        while (issue_ready !== 1'b1) @(posedge clk_sys);
        issue_valid <= 1'b0;
        do begin
            @(posedge clk_sys);
            n = n + 1;
        end while (done_valid !== 1'b1 && n < 40);
        check("done wait", 32'(n >= 40), 32'h0000_0000);
        #1;
    endtask
    task automatic expect_op(input logic [31:0] a, input logic [3:0] be, input logic [31:0] m,
        input logic [31:0] d, input logic [3:0] fl, input logic [4:0] idx);
        check("store addr", store_req.addr, a);
        check("byte enables", 32'(store_req.be), 32'(be));
        check("store data", store_req.data & m, d);
        check("done flags", 32'(done), 32'(fl));
        check("wb count", wb_seen - wb_base, 32'(fl[0]));
        if (fl[0]) begin
            check("wb ea", wb_last.ea, a);
            check("wb idx", 32'(wb_last.idx), 32'(idx));
        end
    endtask
    // main sequence
    initial begin
        errors = 0;
        num_checks = 0;
        wb_seen = 0;
        cycles = 0;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
        check("ctrl reset", rd, 32'h0000_0003);
        ahb(1'b0, 32'h0000_0020, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        $display("test registers done");
        do_op(dfm(6'h35, 5'h06, 5'h04, 16'h0010), 32'h0000_0000, 32'h0000_1000, 32'h0000_0000);
        expect_op(32'h0000_1010, 4'hf, 32'hffff_ffff, 32'h432b_6363, 4'h1, 5'h04);
        do_op(dfm(6'h35, 5'h06, 5'h00, 16'hfff8), 32'h0000_0000, 32'h0000_5555, 32'h0000_0000);
        expect_op(32'hffff_fff8, 4'hf, 32'hffff_ffff, 32'h432b_6363, 4'h0, 5'h00);
        stall <= 4'h3;
        do_op(xfm(5'h06, 5'h05, 5'h04, 10'h2b7), 32'h0000_0000, 32'h0000_2000, 32'h0000_0008);
        expect_op(32'h0000_2008, 4'hf, 32'hffff_ffff, 32'h432b_6363, 4'h1, 5'h05);
        do_op(xfm(5'h06, 5'h00, 5'h04, 10'h297), 32'h0000_0000, 32'h0000_7777, 32'h0000_3000);
        expect_op(32'h0000_3000, 4'hf, 32'hffff_ffff, 32'h432b_6363, 4'h0, 5'h00);
        stall <= 4'h0;
        $display("test float stores done");
        do_op(dfm(6'h2c, 5'h06, 5'h04, 16'h0002), 32'h9000_3000, 32'h0000_0100, 32'h0000_0000);
        expect_op(32'h0000_0102, 4'h3, 32'h0000_ffff, 32'h0000_3000, 4'h0, 5'h00);
        do_op(xfm(5'h06, 5'h00, 5'h04, 10'h396), 32'h9000_3456, 32'h0000_9999, 32'h0000_0200);
        expect_op(32'h0000_0200, 4'hc, 32'hffff_0000, 32'h5634_0000, 4'h0, 5'h00);
        do_op(dfm(6'h2d, 5'h06, 5'h04, 16'hfffe), 32'h9000_3456, 32'h0000_0400, 32'h0000_0000);
        expect_op(32'h0000_03fe, 4'h3, 32'h0000_ffff, 32'h0000_3456, 4'h1, 5'h04);
        fault_cmd <= 1'b1;
        do_op(dfm(6'h2d, 5'h06, 5'h04, 16'hfffe), 32'h9000_3456, 32'h0000_0400, 32'h0000_0000);
        fault_cmd <= 1'b0;
        expect_op(32'h0000_03fe, 4'h3, 32'h0000_ffff, 32'h0000_3456, 4'h4, 5'h04);
        acc0 = accepts;
        do_op(dfm(6'h35, 5'h06, 5'h04, 16'h0002), 32'h0000_0000, 32'h0000_1000, 32'h0000_0000);
        check("align flags", 32'(done), 32'h0000_0008);
        check("no write", 32'(accepts), 32'(acc0));
        check("no update", wb_seen - wb_base, 32'h0000_0000);
        do_op(dfm(6'h34, 5'h06, 5'h04, 16'h0000), 32'h0000_0000, 32'h0000_1000, 32'h0000_0000);
        check("illegal flags", 32'(done), 32'h0000_0002);
        check("no write illegal", 32'(accepts), 32'(acc0));
        $display("test halfword and fault done");
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        check("status", rd, 32'h0000_001f);
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        check("status cleared", rd, 32'h0000_0000);
        do_op(dfm(6'h2c, 5'h06, 5'h00, 16'h0010), 32'h0000_1234, 32'h0000_0000, 32'h0000_0000);
        repeat (2) @(posedge clk_sys);
        check("irq masked", 32'(irq), 32'h0000_0000);
        ahb(1'b1, 32'h0000_0008, 32'h0000_0001);
        repeat (2) @(posedge clk_sys);
        check("irq raised", 32'(irq), 32'h0000_0001);
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        repeat (2) @(posedge clk_sys);
        check("irq cleared", 32'(irq), 32'h0000_0000);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0000);
        @(posedge clk_sys);
        #1;
        check("issue blocked", 32'(issue_ready), 32'h0000_0000);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
        do_op(dfm(6'h2c, 5'h06, 5'h00, 16'h0011), 32'h0000_1234, 32'h0000_0000, 32'h0000_0000);
        expect_op(32'h0000_0011, 4'h6, 32'h00ff_ff00, 32'h0012_3400, 4'h0, 5'h00);
        ahb(1'b0, 32'h0000_000c, 32'h0000_0000);
        check("last ea", rd, 32'h0000_0011);
        ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
        check("count", rd, 32'h0000_0009);
        check("hresp", 32'(hresp), 32'h0000_0000);
        $display("test interrupt done");
        report_and_stop();
    end
endmodule // tb_top
